//--- common/supply_limit_defs.svh
// Purpose: width, field positions, reset values and timing counts of the supply limit register
// Assumes: 125 MHz core clock
// Notes: definitions only
`ifndef SUPPLY_LIMIT_DEFS_SVH
`define SUPPLY_LIMIT_DEFS_SVH

`define SLC_WIDTH 16
`define SLC_RESET 16'hAA90

`define SLC_POS_UV_MSB 15
`define SLC_POS_UV_LSB 14
`define SLC_POS_OV_MSB 13
`define SLC_POS_OV_LSB 12
`define SLC_NEG_UV_MSB 11
`define SLC_NEG_UV_LSB 10
`define SLC_NEG_OV_MSB 9
`define SLC_NEG_OV_LSB 8
`define SLC_SAMP_EN_BIT 7
`define SLC_MODE_MSB 6
`define SLC_MODE_LSB 5
`define SLC_DLY_MSB 4
`define SLC_DLY_LSB 3
`define SLC_REPORT_BIT 2
`define SLC_FS_MSB 1
`define SLC_FS_LSB 0

`define CLK_PERIOD_NS 8
`define SAMP_DLY0_NS 280
`define SAMP_DLY1_NS 560
`define SAMP_DLY2_NS 840
`define SAMP_DLY3_NS 1120
// least times, rounded up to whole cycles
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CNT_WIDTH 12
`define NUM_FAULT_SRC 4

`endif

//--- common/supply_limit_pkg.sv
// Purpose: types shared by the supply limit register and the sample timer
// Assumes: nothing
// Notes: field values and counts live in supply_limit_defs.svh
`default_nettype none
package supply_limit_pkg;

	typedef enum logic [1:0] {
		SAMP_CENTER,
		SAMP_EDGE,
		SAMP_HYBRID,
		SAMP_RESERVED
	} samp_mode_t;

	typedef enum logic [1:0] {
		FS_PULL_LOW,
		FS_PULL_HIGH,
		FS_HI_Z,
		FS_NO_ACTION
	} fs_state_t;

	typedef struct packed {
		logic [1:0] pos_uv_code;
		logic [1:0] pos_ov_code;
		logic [1:0] neg_uv_code;
		logic [1:0] neg_ov_code;
		logic samp_en;
		samp_mode_t samp_mode;
		logic [1:0] samp_dly_code;
		logic report_en;
		fs_state_t fs_state;
	} slc_fields_t;

	// threshold pairs in millivolts, signed
	typedef struct packed {
		logic signed [15:0] pos_uv_rise_mv;
		logic signed [15:0] pos_uv_fall_mv;
		logic signed [15:0] pos_ov_recover_mv;
		logic signed [15:0] pos_ov_trip_mv;
		logic signed [15:0] neg_uv_on_mv;
		logic signed [15:0] neg_uv_off_mv;
		logic signed [15:0] neg_ov_on_mv;
		logic signed [15:0] neg_ov_off_mv;
	} thresholds_t;

	typedef struct packed {
		logic pullup_en_n;
		logic pulldown_en_n;
	} gate_drive_t;

endpackage
`default_nettype wire

//--- rtl/converter_sample_timer.sv
// Purpose: places the converter sampling point after each pwm rising edge
// Assumes: pwm synchronous to clk
// Notes: center modes use the previous high time, so the first pulse after reset is edge-timed or skipped
`timescale 1ns/1ns
`default_nettype none
`include "supply_limit_defs.svh"
module converter_sample_timer (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// configuration
	input wire logic samp_en,
	input wire supply_limit_pkg::samp_mode_t samp_mode,
	input wire logic [`CNT_WIDTH-1:0] min_delay_cyc,
	// pwm and strobe
	input wire logic pwm,
	output logic sample_pulse
);
	import supply_limit_pkg::*;

	logic pwm_q;
	logic armed_q, armed_d;
	logic [`CNT_WIDTH-1:0] cnt_q, cnt_d;
	logic [`CNT_WIDTH-1:0] half_q, half_d;
	logic pulse_q, pulse_d;

	wire rise = pwm & ~pwm_q;
	wire fall = ~pwm & pwm_q;
	wire cnt_max = &cnt_q;
	wire half_ok = half_q >= min_delay_cyc;
	wire [`CNT_WIDTH-1:0] hybrid_tgt = half_ok ? half_q : min_delay_cyc;
	logic [`CNT_WIDTH-1:0] target;
	logic mode_ok;

	always_comb begin
		target = min_delay_cyc;
		mode_ok = 1'b1;
		case (samp_mode)
			SAMP_EDGE: target = min_delay_cyc;
			// centre sample that would break the minimum delay is skipped
			SAMP_CENTER: begin
				target = half_q;
				mode_ok = half_ok;
			end
			SAMP_HYBRID: target = hybrid_tgt;
			default: mode_ok = 1'b0;
		endcase
	end

	always_comb begin
		cnt_d = cnt_max ? cnt_q : cnt_q + `CNT_WIDTH'(1);
		armed_d = armed_q;
		half_d = half_q;
		pulse_d = 1'b0;
		if (rise) begin
			cnt_d = '0;
			armed_d = samp_en & mode_ok;
		end else if (armed_q && cnt_q >= target && cnt_q >= min_delay_cyc) begin
			pulse_d = samp_en;
			armed_d = 1'b0;
		end
		if (fall) begin
			half_d = {1'b0, cnt_q[`CNT_WIDTH-1:1]};
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pwm_q <= 1'b0;
			armed_q <= 1'b0;
			cnt_q <= '0;
			half_q <= '0;
			pulse_q <= 1'b0;
		end else begin
			pwm_q <= pwm;
			armed_q <= armed_d;
			cnt_q <= cnt_d;
			half_q <= half_d;
			pulse_q <= pulse_d;
		end
	end

	assign sample_pulse = pulse_q;

endmodule // converter_sample_timer
`default_nettype wire

//--- rtl/supply_limit_adc_config.sv
// Purpose: supply limit and converter configuration register with its fault and sampling logic
// Assumes: register port driven by the serial configuration interface on clk
// Notes: thresholds leave as codes and as millivolt values for the analog comparators
`timescale 1ns/1ns
`default_nettype none
`include "supply_limit_defs.svh"
module supply_limit_adc_config (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic cfg_wr,
	input wire logic [`SLC_WIDTH-1:0] cfg_wdata,
	output logic [`SLC_WIDTH-1:0] cfg_rdata,
	// threshold selections
	output logic [1:0] pos_supply_undervolt_threshold,
	output logic [1:0] pos_supply_overvolt_threshold,
	output logic [1:0] neg_supply_undervolt_threshold,
	output logic [1:0] neg_supply_overvolt_threshold,
	output supply_limit_pkg::thresholds_t thresholds,
	// converter sampling
	input wire logic pwm,
	output logic converter_sample_strobe,
	// converter faults, mask bit high hides a source
	input wire logic [`NUM_FAULT_SRC-1:0] conv_fault_src,
	input wire logic [`NUM_FAULT_SRC-1:0] conv_fault_mask,
	output logic fault_alarm_output_n,
	// gate outputs, enables low while driving
	output supply_limit_pkg::gate_drive_t gate_drive
);
	import supply_limit_pkg::*;

	logic [`SLC_WIDTH-1:0] reg_q;
	logic [`SLC_WIDTH-1:0] reg_d;
	slc_fields_t fld;
	thresholds_t thr_d;
	thresholds_t thr_q;
	gate_drive_t drive_d;
	gate_drive_t drive_q;
	logic alarm_n_q;
	logic strobe_q;
	logic sample_pulse;
	logic [`CNT_WIDTH-1:0] delay_cyc;

	// register storage
	// one word, every field read/write; code 3 in the mode field is kept as written
	assign reg_d = cfg_wr ? cfg_wdata : reg_q;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			reg_q <= `SLC_RESET;
		end else begin
			reg_q <= reg_d;
		end
	end

	// field decode
	// enum casts are safe: all four codes of both fields are named
	assign fld.pos_uv_code = reg_q[`SLC_POS_UV_MSB:`SLC_POS_UV_LSB];
	assign fld.pos_ov_code = reg_q[`SLC_POS_OV_MSB:`SLC_POS_OV_LSB];
	assign fld.neg_uv_code = reg_q[`SLC_NEG_UV_MSB:`SLC_NEG_UV_LSB];
	assign fld.neg_ov_code = reg_q[`SLC_NEG_OV_MSB:`SLC_NEG_OV_LSB];
	assign fld.samp_en = reg_q[`SLC_SAMP_EN_BIT];
	assign fld.samp_mode = samp_mode_t'(reg_q[`SLC_MODE_MSB:`SLC_MODE_LSB]);
	assign fld.samp_dly_code = reg_q[`SLC_DLY_MSB:`SLC_DLY_LSB];
	assign fld.report_en = reg_q[`SLC_REPORT_BIT];
	assign fld.fs_state = fs_state_t'(reg_q[`SLC_FS_MSB:`SLC_FS_LSB]);

	// millivolt lookups; a code step is a fixed pair, so each is one small table
	function automatic logic signed [15:0] pos_uv_rise(input logic [1:0] c);
		case (c)
			2'h0: pos_uv_rise = 16'sd16000;
			2'h1: pos_uv_rise = 16'sd14000;
			2'h2: pos_uv_rise = 16'sd12000;
			default: pos_uv_rise = 16'sd10000;
		endcase
	endfunction

	function automatic logic signed [15:0] pos_ov_recover(input logic [1:0] c);
		case (c)
			2'h0: pos_ov_recover = 16'sd23000;
			2'h1: pos_ov_recover = 16'sd21000;
			2'h2: pos_ov_recover = 16'sd19000;
			default: pos_ov_recover = 16'sd17000;
		endcase
	endfunction

	function automatic logic signed [15:0] neg_uv_on(input logic [1:0] c);
		case (c)
			2'h0: neg_uv_on = -16'sd3000;
			2'h1: neg_uv_on = -16'sd5000;
			2'h2: neg_uv_on = -16'sd8000;
			default: neg_uv_on = -16'sd10000;
		endcase
	endfunction

	function automatic logic signed [15:0] neg_ov_on(input logic [1:0] c);
		case (c)
			2'h0: neg_ov_on = -16'sd5000;
			2'h1: neg_ov_on = -16'sd7000;
			2'h2: neg_ov_on = -16'sd10000;
			default: neg_ov_on = -16'sd12000;
		endcase
	endfunction

	// second value of every pair sits 1 V from the first
	assign thr_d.pos_uv_rise_mv = pos_uv_rise(fld.pos_uv_code);
	assign thr_d.pos_uv_fall_mv = pos_uv_rise(fld.pos_uv_code) - 16'sd1000;
	assign thr_d.pos_ov_recover_mv = pos_ov_recover(fld.pos_ov_code);
	assign thr_d.pos_ov_trip_mv = pos_ov_recover(fld.pos_ov_code) + 16'sd1000;
	assign thr_d.neg_uv_on_mv = neg_uv_on(fld.neg_uv_code);
	assign thr_d.neg_uv_off_mv = neg_uv_on(fld.neg_uv_code) + 16'sd1000;
	assign thr_d.neg_ov_on_mv = neg_ov_on(fld.neg_ov_code);
	assign thr_d.neg_ov_off_mv = neg_ov_on(fld.neg_ov_code) - 16'sd1000;

	// sampling delay in cycles, least time rounded up
	// 8 ns clock divides every step exactly, so the rounding never adds a cycle
	wire [`CNT_WIDTH-1:0] dly0_cyc = `CNT_WIDTH'(`NS_TO_CYC(`SAMP_DLY0_NS));
	wire [`CNT_WIDTH-1:0] dly1_cyc = `CNT_WIDTH'(`NS_TO_CYC(`SAMP_DLY1_NS));
	wire [`CNT_WIDTH-1:0] dly2_cyc = `CNT_WIDTH'(`NS_TO_CYC(`SAMP_DLY2_NS));
	wire [`CNT_WIDTH-1:0] dly3_cyc = `CNT_WIDTH'(`NS_TO_CYC(`SAMP_DLY3_NS));

	always_comb begin
		case (fld.samp_dly_code)
			2'h0: delay_cyc = dly0_cyc;
			2'h1: delay_cyc = dly1_cyc;
			2'h2: delay_cyc = dly2_cyc;
			default: delay_cyc = dly3_cyc;
		endcase
	end

	// reserved mode code 3 stops sampling rather than guessing a placement;
	// the enable is gated too, so code 3 written after a rise also drops an armed sample
	wire samp_allowed = fld.samp_en & (fld.samp_mode != SAMP_RESERVED);
	converter_sample_timer u_timer (
		.clk(clk),
		.nrst(nrst),
		.samp_en(samp_allowed),
		.samp_mode(fld.samp_mode),
		.min_delay_cyc(delay_cyc),
		.pwm(pwm),
		.sample_pulse(sample_pulse)
	);

	// converter fault qualification, one gate per source
	// a high mask bit hides its source from the alarm and the gate override alike
	wire [`NUM_FAULT_SRC-1:0] fault_live;
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_FAULT_SRC; gi = gi + 1) begin : g_fault
			assign fault_live[gi] = conv_fault_src[gi] & ~conv_fault_mask[gi];
		end
	endgenerate

	wire fault_any = |fault_live;
	wire alarm_n_d = ~(fault_any & fld.report_en);

	// gate drive: normal follows pwm, fault state overrides unless no action
	// limitation: both stages swap in one cycle, no dead time is inserted here
	always_comb begin
		drive_d.pullup_en_n = ~pwm;
		drive_d.pulldown_en_n = pwm;
		if (fault_any) begin
			case (fld.fs_state)
				FS_PULL_LOW: begin
					drive_d.pullup_en_n = 1'b1;
					drive_d.pulldown_en_n = 1'b0;
				end
				FS_PULL_HIGH: begin
					drive_d.pullup_en_n = 1'b0;
					drive_d.pulldown_en_n = 1'b1;
				end
				FS_HI_Z: begin
					drive_d.pullup_en_n = 1'b1;
					drive_d.pulldown_en_n = 1'b1;
				end
				default: begin
					drive_d.pullup_en_n = ~pwm;
					drive_d.pulldown_en_n = pwm;
				end
			endcase
		end
	end

	// output flops; the gate defaults to pulled low while in reset
	// thresholds read zero in reset and settle one edge after release
	always_ff @(posedge clk) begin
		if (!nrst) begin
			thr_q <= '0;
			drive_q <= '{pullup_en_n: 1'b1, pulldown_en_n: 1'b0};
			alarm_n_q <= 1'b1;
			strobe_q <= 1'b0;
		end else begin
			thr_q <= thr_d;
			drive_q <= drive_d;
			alarm_n_q <= alarm_n_d;
			strobe_q <= sample_pulse;
		end
	end

	// codes come straight off the register flops, no extra stage
	assign cfg_rdata = reg_q;
	assign pos_supply_undervolt_threshold = reg_q[`SLC_POS_UV_MSB:`SLC_POS_UV_LSB];
	assign pos_supply_overvolt_threshold = reg_q[`SLC_POS_OV_MSB:`SLC_POS_OV_LSB];
	assign neg_supply_undervolt_threshold = reg_q[`SLC_NEG_UV_MSB:`SLC_NEG_UV_LSB];
	assign neg_supply_overvolt_threshold = reg_q[`SLC_NEG_OV_MSB:`SLC_NEG_OV_LSB];
	assign thresholds = thr_q;
	assign converter_sample_strobe = strobe_q;
	assign fault_alarm_output_n = alarm_n_q;
	assign gate_drive = drive_q;

endmodule // supply_limit_adc_config
`default_nettype wire

//--- test/supply_limit_adc_config_props.sv
// Purpose: port checks of the supply limit register
// Assumes: one clock domain, nrst synchronous and active low
// Notes: bound to the design top after the module
`timescale 1ns/1ns
`default_nettype none
`include "supply_limit_defs.svh"
module supply_limit_adc_config_props (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic cfg_wr,
	input wire logic [`SLC_WIDTH-1:0] cfg_wdata,
	input wire logic [`SLC_WIDTH-1:0] cfg_rdata,
	// threshold selections
	input wire logic [1:0] pos_supply_undervolt_threshold,
	input wire logic [1:0] pos_supply_overvolt_threshold,
	input wire logic [1:0] neg_supply_undervolt_threshold,
	input wire logic [1:0] neg_supply_overvolt_threshold,
	input wire supply_limit_pkg::thresholds_t thresholds,
	// sampling and faults
	input wire logic pwm,
	input wire logic converter_sample_strobe,
	input wire logic [`NUM_FAULT_SRC-1:0] conv_fault_src,
	input wire logic [`NUM_FAULT_SRC-1:0] conv_fault_mask,
	input wire logic fault_alarm_output_n,
	input wire supply_limit_pkg::gate_drive_t gate_drive
);
	import supply_limit_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic fault_w = |(conv_fault_src & ~conv_fault_mask);
	function automatic logic [1:0] exp_gate(input logic f, input logic [1:0] s, input logic p);
		if (f && s != 2'h3)
			return (s == 2'h0) ? 2'h2 : (s == 2'h1) ? 2'h1 : 2'h3;
		return p ? 2'h1 : 2'h2;
	endfunction
	sequence s_rise_edge0; $rose(pwm) && cfg_rdata[7:3] == 5'h14; endsequence
	sequence s_late_strobe; !converter_sample_strobe[*8] ##1 converter_sample_strobe; endsequence
	property p_wr_take; cfg_wr |=> cfg_rdata == $past(cfg_wdata); endproperty
	property p_hold; !cfg_wr |=> $stable(cfg_rdata); endproperty
	property p_rst; $rose(nrst) |-> cfg_rdata == 16'haa90; endproperty
	property p_fields; cfg_rdata[15:8] == {pos_supply_undervolt_threshold, pos_supply_overvolt_threshold,
		neg_supply_undervolt_threshold, neg_supply_overvolt_threshold}; endproperty
	property p_thr_uv; $past(nrst) |-> thresholds.pos_uv_rise_mv == 16'h3e80 - 16'h07d0 * $past(cfg_rdata[15:14])
		&& thresholds.pos_uv_fall_mv == thresholds.pos_uv_rise_mv - 16'h03e8; endproperty
	property p_thr_ov; $past(nrst) |-> thresholds.pos_ov_trip_mv == 16'h5dc0 - 16'h07d0 * $past(cfg_rdata[13:12])
		&& thresholds.pos_ov_recover_mv == thresholds.pos_ov_trip_mv - 16'h03e8; endproperty
	property p_alarm; $past(nrst) |-> fault_alarm_output_n == !($past(fault_w) && $past(cfg_rdata[2])); endproperty
	property p_gate; $past(nrst) |-> gate_drive == exp_gate($past(fault_w), $past(cfg_rdata[1:0]), $past(pwm));
	endproperty
	property p_pulse; converter_sample_strobe |=> !converter_sample_strobe; endproperty
	property p_edge0; s_rise_edge0 |-> ##30 s_late_strobe; endproperty
	property p_off; (!cfg_rdata[7] || cfg_rdata[6:5] == 2'h3)[*3] |-> !converter_sample_strobe; endproperty
	a_wr_take: assert property (p_wr_take) else $error("write data not stored");
	a_hold: assert property (p_hold) else $error("register changed without write");
	a_rst: assert property (p_rst) else $error("wrong reset contents");
	a_fields: assert property (p_fields) else $error("threshold code mismatch");
	a_thr_uv: assert property (p_thr_uv) else $error("positive undervoltage pair wrong");
	a_thr_ov: assert property (p_thr_ov) else $error("positive overvoltage pair wrong");
	a_alarm: assert property (p_alarm) else $error("alarm output wrong");
	a_gate: assert property (p_gate) else $error("gate drive wrong");
	a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
	a_edge0: assert property (p_edge0) else $error("edge strobe misplaced");
	a_off: assert property (p_off) else $error("strobe while sampling off");
endmodule // supply_limit_adc_config_props
bind supply_limit_adc_config supply_limit_adc_config_props u_props (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr),
	.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .pos_supply_undervolt_threshold(pos_supply_undervolt_threshold),
	.pos_supply_overvolt_threshold(pos_supply_overvolt_threshold), .thresholds(thresholds), .pwm(pwm),
	.neg_supply_undervolt_threshold(neg_supply_undervolt_threshold), .gate_drive(gate_drive),
	.neg_supply_overvolt_threshold(neg_supply_overvolt_threshold), .converter_sample_strobe(converter_sample_strobe),
	.conv_fault_src(conv_fault_src), .conv_fault_mask(conv_fault_mask), .fault_alarm_output_n(fault_alarm_output_n));
`default_nettype wire

//--- test/tb_top.sv
// Purpose: self-checking bench for the supply limit register
// Assumes: 125 MHz clock, inputs driven on falling edges
// Notes: pulses stay high 160 cycles so the longest delay fits
`timescale 1ns/1ns
`default_nettype none
`include "supply_limit_defs.svh"
module tb_top;
	import supply_limit_pkg::*;
	logic clk, nrst, cfg_wr, pwm, strobe, alarm_n;
	logic [15:0] cfg_wdata, cfg_rdata;
	logic [1:0] puv, pov, nuv, nov;
	thresholds_t thr;
	gate_drive_t gate;
	logic [3:0] src, mask;
	int num_errors, total_checks, seed, model, first, cnt, m, lat, half, dly;
	supply_limit_adc_config dut (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .pos_supply_undervolt_threshold(puv), .pos_supply_overvolt_threshold(pov),
		.neg_supply_undervolt_threshold(nuv), .neg_supply_overvolt_threshold(nov), .thresholds(thr), .pwm(pwm),
		.converter_sample_strobe(strobe), .conv_fault_src(src), .conv_fault_mask(mask),
		.fault_alarm_output_n(alarm_n), .gate_drive(gate));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic thresholds_t exp_thr(input int v);
		int uv[4] = '{-3000, -5000, -8000, -10000};
		int ov[4] = '{-5000, -7000, -10000, -12000};
		int a, b;
		a = (v >> 14) & 3;
		b = (v >> 12) & 3;
		return '{16'(16000 - 2000 * a), 16'(15000 - 2000 * a), 16'(23000 - 2000 * b), 16'(24000 - 2000 * b),
			16'(uv[(v >> 10) & 3]), 16'(uv[(v >> 10) & 3] + 1000), 16'(ov[(v >> 8) & 3]), 16'(ov[(v >> 8) & 3] - 1000)};
	endfunction
	function automatic logic [1:0] gexp(input logic f, input logic [1:0] s, input logic p);
		if (f && s != 2'h3)
			return (s == 2'h0) ? 2'h2 : (s == 2'h1) ? 2'h1 : 2'h3;
		return p ? 2'h1 : 2'h2;
	endfunction
	task automatic wr(input logic [15:0] d);
		cfg_wr = 1;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 0;
		model = d;
	endtask
	// thresholds trail the field by one cycle, so look two edges after the write
	task automatic check_regs();
		@(negedge clk);
		chk("cfg_rdata", model[15:0], cfg_rdata);
		chk("codes", model[15:8], {puv, pov, nuv, nov});
		chk("thresholds", exp_thr(model), thr);
	endtask
	task automatic pulse();
		pwm = 1;
		first = 0;
		cnt = 0;
		for (int i = 1; i <= 200; i++) begin
			@(negedge clk);
			if (i == 160)
				pwm = 0;
			// an unknown strobe counts, so it cannot slip past an expected zero
			if (strobe !== 1'b0) begin
				cnt++;
				if (first == 0)
					first = i;
			end
		end
	endtask
	initial begin
		#200000;
		num_errors++;
		complete_run();
	end
	initial begin
		seed = 32'h49cc;
		{nrst, cfg_wr, pwm, cfg_wdata, src, mask} = '0;
		num_errors = 0;
		total_checks = 0;
		repeat (10) @(negedge clk);
		nrst = 1;
		model = 32'h0000_aa90;
		check_regs();
		for (int c = 0; c < 4; c++) begin
			wr({c[1:0], c[1:0], c[1:0], c[1:0], 8'h90});
			check_regs();
		end
		repeat (12) begin
			cfg_wr = 1;
			cfg_wdata = 16'($random(seed));
			@(negedge clk);
			cfg_wdata = 16'($random(seed));
			model = cfg_wdata;
			@(negedge clk);
			cfg_wr = 0;
			check_regs();
		end
		// reset in mid-run must restore every field
		nrst = 0;
		@(negedge clk);
		nrst = 1;
		model = 32'h0000_aa90;
		check_regs();
		for (int k = 0; k < 64; k++) begin
			wr({8'haa, 5'h12, k[2], k[1:0]});
			src = 4'h1 << k[4:3];
			mask = k[5] ? src : 4'h0;
			pwm = 1'($random(seed));
			@(negedge clk);
			chk("alarm_n", !(k[2] && !k[5]), alarm_n);
			chk("gate", gexp(!k[5], k[1:0], pwm), gate);
		end
		src = 4'h0;
		pwm = 0;
		// second reset clears the sampling history, so the first center pulse has none
		nrst = 0;
		@(negedge clk);
		nrst = 1;
		half = 0;
		model = 32'h0000_aa90;
		check_regs();
		repeat (40) @(negedge clk);
		for (int k = 0; k < 17; k++) begin
			wr({8'haa, k < 16, k[3:2], k[1:0], 3'h0});
			m = k[3:2];
			dly = 280 * (k[1:0] + 1) / `CLK_PERIOD_NS;
			repeat (2) begin
				// strobe shows three negedges after the target count; center needs half at least the delay
				lat = (k == 16 || m == 3 || (m == 0 && half < dly)) ? 0 : (m == 1 || half < dly) ? dly + 3 : half + 3;
				pulse();
				// counter starts one edge after the rise, so 160 high cycles leave 159 to halve
				half = (160 - 1) / 2;
				chk("strobes", lat != 0, cnt);
				if (lat != 0)
					chk("delay", lat, first);
			end
		end
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
